// *** src/rop_combiner.sv ***
`default_nettype none
module rop_combiner
  import rop_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic dm_wr_q,
  output logic [63:0] dm_data_q,
  output logic [63:0] dm_bit_we_q
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] combine(input logic [2:0] op, input logic c,
                                          input logic [15:0] d, input logic [15:0] s);
    logic [15:0] r;
    r = d;
    unique case (op)
      ROP_LSET: r = s;
      ROP_LOR: r = d | s;
      ROP_LAND: r = d & s;
      ROP_LXOR: r = d ^ s;
      ROP_LZERO: r = d & ~s;
      ROP_GSET: r = c ? (d | s) : (d & ~s);
      ROP_GOR: r = c ? (d | s) : d;
      ROP_GXOR: r = c ? (d ^ s) : d;
    endcase
    return r;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ROP_STATUS_OFS);
  endfunction

  logic [7:0] ctrl_q;
  logic [3:0] color_q;
  logic [3:0] search_q;
  logic [3:0] active_q;
  logic [15:0] wmask_q;
  logic [15:0] imask_q;
  logic [3:0][15:0] src_q;
  logic [3:0][15:0] dst_q;
  logic done_q;
  logic [3:0] pwr_q;
  logic hassrc_q;

  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic do_wr;
  logic go;
  logic [2:0] op;
  logic [2:0] iclass;
  logic inv;
  logic brush;
  logic has_src;
  logic [3:0][15:0] res_w;
  logic [3:0][15:0] bwe_w;
  logic [31:0] wr_old;
  logic [31:0] wr_new;

  assign op = ctrl_q[ROP_CODE_LSB +: 3];
  assign inv = ctrl_q[ROP_INV_BIT];
  assign iclass = ctrl_q[ROP_CLASS_LSB +: 3];
  assign brush = ctrl_q[ROP_BRUSH_BIT];

  // source present for block moves, or for point, line, arc and circle drawing when the brush is on; never for fill
  always_comb begin
    unique case (iclass)
      ROP_I_COPY, ROP_I_STRING, ROP_I_XFORM: has_src = 1'b1;
      ROP_I_POINT, ROP_I_LINE, ROP_I_ARC, ROP_I_CIRCLE: has_src = brush;
      ROP_I_FILL: has_src = 1'b0;
    endcase
  end

  // ---------------- axi write channel ----------------
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign do_wr = aw_full_q && w_full_q && !bvalid_q;
  assign go = do_wr && (awaddr_q == ROP_GO_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_wr) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= ROP_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_ok(awaddr_q) ? ROP_RESP_OKAY : ROP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---------------- configuration registers ----------------
  // present contents of the addressed register, so cleared strobes keep their bytes
  always_comb begin
    unique case (awaddr_q)
      ROP_CTRL_OFS: wr_old = {24'h00_0000, ctrl_q};
      ROP_COLOR_OFS: wr_old = {28'h000_0000, color_q};
      ROP_SEARCH_OFS: wr_old = {28'h000_0000, search_q};
      ROP_ACTIVE_OFS: wr_old = {28'h000_0000, active_q};
      ROP_WMASK_OFS: wr_old = {16'h0000, wmask_q};
      ROP_IMASK_OFS: wr_old = {16'h0000, imask_q};
      ROP_SRC01_OFS: wr_old = src_q[1:0];
      ROP_SRC23_OFS: wr_old = src_q[3:2];
      ROP_DST01_OFS: wr_old = dst_q[1:0];
      ROP_DST23_OFS: wr_old = dst_q[3:2];
      default: wr_old = 32'h0000_0000;
    endcase
  end
  assign wr_new = merge(wr_old, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ROP_CTRL_RST;
      color_q <= ROP_COLOR_RST;
      search_q <= ROP_SEARCH_RST;
      active_q <= ROP_ACTIVE_RST;
      wmask_q <= ROP_WMASK_RST;
      imask_q <= ROP_IMASK_RST;
      src_q <= '0;
      dst_q <= '0;
    end else if (do_wr) begin
      unique case (awaddr_q)
        ROP_CTRL_OFS: ctrl_q <= wr_new[7:0];
        ROP_COLOR_OFS: color_q <= wr_new[3:0];
        ROP_SEARCH_OFS: search_q <= wr_new[3:0];
        ROP_ACTIVE_OFS: active_q <= wr_new[3:0];
        ROP_WMASK_OFS: wmask_q <= wr_new[15:0];
        ROP_IMASK_OFS: imask_q <= wr_new[15:0];
        ROP_SRC01_OFS: src_q[1:0] <= wr_new;
        ROP_SRC23_OFS: src_q[3:2] <= wr_new;
        ROP_DST01_OFS: dst_q[1:0] <= wr_new;
        ROP_DST23_OFS: dst_q[3:2] <= wr_new;
        default: ; // read-only, go or unmapped: nothing stored
      endcase
    end
  end

  // ---------------- per-plane datapath ----------------
  for (genvar p = 0; p < ROP_PLANES; p++) begin : g_plane
    logic [15:0] s_eff;
    // no source: the interpolation mask stands in for it
    assign s_eff = has_src ? (src_q[p] ^ {16{inv}}) : imask_q;
    assign bwe_w[p] = active_q[p] ? wmask_q : 16'h0000;
    assign res_w[p] = (combine(op, color_q[p], dst_q[p], s_eff) & bwe_w[p])
                      | (dst_q[p] & ~bwe_w[p]);
  end

  // result is captured on go; memory write strobe lasts one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dm_wr_q <= 1'b0;
      dm_data_q <= '0;
      dm_bit_we_q <= '0;
      pwr_q <= 4'h0;
      hassrc_q <= 1'b0;
    end else begin
      dm_wr_q <= go;
      if (go) begin
        dm_data_q <= res_w;
        dm_bit_we_q <= bwe_w;
        pwr_q <= (wmask_q != 16'h0000) ? active_q : 4'h0;
        hassrc_q <= has_src;
      end
    end
  end

  // done is sticky until the next go
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else if (dm_wr_q) begin
      done_q <= 1'b1;
    end else if (go) begin
      done_q <= 1'b0;
    end
  end

  // ---------------- axi read channel ----------------
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= ROP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= addr_ok(s_axi_araddr) ? ROP_RESP_OKAY : ROP_RESP_SLVERR;
      unique case (s_axi_araddr)
        ROP_CTRL_OFS: rdata_q <= {24'h0000_00, ctrl_q};
        ROP_COLOR_OFS: rdata_q <= {28'h000_0000, color_q};
        ROP_SEARCH_OFS: rdata_q <= {28'h000_0000, search_q};
        ROP_ACTIVE_OFS: rdata_q <= {28'h000_0000, active_q};
        ROP_WMASK_OFS: rdata_q <= {16'h0000, wmask_q};
        ROP_IMASK_OFS: rdata_q <= {16'h0000, imask_q};
        ROP_SRC01_OFS: rdata_q <= src_q[1:0];
        ROP_SRC23_OFS: rdata_q <= src_q[3:2];
        ROP_DST01_OFS: rdata_q <= dst_q[1:0];
        ROP_DST23_OFS: rdata_q <= dst_q[3:2];
        ROP_RES01_OFS: rdata_q <= dm_data_q[31:0];
        ROP_RES23_OFS: rdata_q <= dm_data_q[63:32];
        ROP_STATUS_OFS: rdata_q <= {26'h000_0000, pwr_q, hassrc_q, done_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // go with every plane and every bit enabled
  sequence s_full_go;
    go && active_q == 4'hF && wmask_q == 16'hFFFF;
  endsequence

  sequence s_src_go(logic [2:0] code);
    s_full_go ##0 (has_src && !inv && op == code);
  endsequence

  sequence s_nosrc_go(logic [2:0] code);
    s_full_go ##0 (!has_src && op == code);
  endsequence

  property p_strobe;
    go |=> dm_wr_q ##1 (!dm_wr_q && done_q);
  endproperty
  a_strobe: assert property (p_strobe) else $error("write strobe or done wrong");

  property p_lset;
    s_src_go(ROP_LSET) |=> dm_data_q[15:0] == $past(src_q[0]);
  endproperty
  a_lset: assert property (p_lset) else $error("logical set wrong");

  property p_lor;
    s_src_go(ROP_LOR) |=> dm_data_q[31:16] == ($past(src_q[1]) | $past(dst_q[1]));
  endproperty
  a_lor: assert property (p_lor) else $error("logical or wrong");

  property p_land;
    s_src_go(ROP_LAND) |=> dm_data_q[47:32] == ($past(src_q[2]) & $past(dst_q[2]));
  endproperty
  a_land: assert property (p_land) else $error("logical and wrong");

  property p_lxor;
    s_src_go(ROP_LXOR) |=> dm_data_q[63:48] == ($past(src_q[3]) ^ $past(dst_q[3]));
  endproperty
  a_lxor: assert property (p_lxor) else $error("logical xor wrong");

  property p_lzero;
    s_src_go(ROP_LZERO) |=> dm_data_q[15:0] == ($past(dst_q[0]) & ~$past(src_q[0]));
  endproperty
  a_lzero: assert property (p_lzero) else $error("logical zero wrong");

  property p_gset_c0;
    s_src_go(ROP_GSET) ##0 !color_q[0]
      |=> dm_data_q[15:0] == ($past(dst_q[0]) & ~$past(src_q[0]));
  endproperty
  a_gset_c0: assert property (p_gset_c0) else $error("graphical set colour 0 wrong");

  property p_gor_c0;
    s_src_go(ROP_GOR) ##0 !color_q[1] |=> dm_data_q[31:16] == $past(dst_q[1]);
  endproperty
  a_gor_c0: assert property (p_gor_c0) else $error("graphical or colour 0 wrong");

  property p_gxor_c1;
    s_src_go(ROP_GXOR) ##0 color_q[2]
      |=> dm_data_q[47:32] == ($past(dst_q[2]) ^ $past(src_q[2]));
  endproperty
  a_gxor_c1: assert property (p_gxor_c1) else $error("graphical xor colour 1 wrong");

  property p_class;
    (iclass == ROP_I_FILL) |-> !has_src;
  endproperty
  a_class: assert property (p_class) else $error("fill must have no source");

  property p_ns_gset;
    s_nosrc_go(ROP_GSET)
      |=> (dm_data_q[15:0] & $past(imask_q)) == ({16{$past(color_q[0])}} & $past(imask_q));
  endproperty
  a_ns_gset: assert property (p_ns_gset) else $error("colour write wrong");

  property p_ns_zero;
    s_nosrc_go(ROP_LZERO) |=> (dm_data_q[15:0] & $past(imask_q)) == 16'h0000;
  endproperty
  a_ns_zero: assert property (p_ns_zero) else $error("no-source zero wrong");

  property p_inactive;
    go && !active_q[3] |=> dm_data_q[63:48] == $past(dst_q[3]) && dm_bit_we_q[63:48] == 16'h0000;
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive plane written");

  property p_inv;
    s_full_go ##0 (has_src && inv && op == ROP_LSET) |=> dm_data_q[15:0] == ~$past(src_q[0]);
  endproperty
  a_inv: assert property (p_inv) else $error("source invert wrong");

  property p_wmask;
    go && active_q[0]
      |=> (dm_data_q[15:0] & ~$past(wmask_q)) == ($past(dst_q[0]) & ~$past(wmask_q));
  endproperty
  a_wmask: assert property (p_wmask) else $error("masked bits changed");

endmodule : rop_combiner
`default_nettype wire

// *** src/rop_pkg.sv ***
`default_nettype none
package rop_pkg;
  localparam int ROP_PLANES = 4;
  localparam int ROP_WORD = 16;
  // register byte offsets
  localparam logic [7:0] ROP_CTRL_OFS = 8'h00;
  localparam logic [7:0] ROP_COLOR_OFS = 8'h04;
  localparam logic [7:0] ROP_SEARCH_OFS = 8'h08;
  localparam logic [7:0] ROP_ACTIVE_OFS = 8'h0C;
  localparam logic [7:0] ROP_WMASK_OFS = 8'h10;
  localparam logic [7:0] ROP_IMASK_OFS = 8'h14;
  localparam logic [7:0] ROP_SRC01_OFS = 8'h18;
  localparam logic [7:0] ROP_SRC23_OFS = 8'h1C;
  localparam logic [7:0] ROP_DST01_OFS = 8'h20;
  localparam logic [7:0] ROP_DST23_OFS = 8'h24;
  localparam logic [7:0] ROP_GO_OFS = 8'h28;
  localparam logic [7:0] ROP_RES01_OFS = 8'h2C;
  localparam logic [7:0] ROP_RES23_OFS = 8'h30;
  localparam logic [7:0] ROP_STATUS_OFS = 8'h34;
  // control register fields
  localparam int ROP_CODE_LSB = 0;
  localparam int ROP_INV_BIT = 3;
  localparam int ROP_CLASS_LSB = 4;
  localparam int ROP_BRUSH_BIT = 7;
  // status register fields
  localparam int ROP_DONE_BIT = 0;
  localparam int ROP_HASSRC_BIT = 1;
  localparam int ROP_PWR_LSB = 2;
  // reset values
  localparam logic [7:0] ROP_CTRL_RST = 8'h00;
  localparam logic [3:0] ROP_COLOR_RST = 4'h0;
  localparam logic [3:0] ROP_SEARCH_RST = 4'h0;
  localparam logic [3:0] ROP_ACTIVE_RST = 4'hF;
  localparam logic [15:0] ROP_WMASK_RST = 16'hFFFF;
  localparam logic [15:0] ROP_IMASK_RST = 16'h0000;
  // raster operation codes
  localparam logic [2:0] ROP_LSET = 3'h0;
  localparam logic [2:0] ROP_LOR = 3'h1;
  localparam logic [2:0] ROP_LAND = 3'h2;
  localparam logic [2:0] ROP_LXOR = 3'h3;
  localparam logic [2:0] ROP_LZERO = 3'h4;
  localparam logic [2:0] ROP_GSET = 3'h5;
  localparam logic [2:0] ROP_GOR = 3'h6;
  localparam logic [2:0] ROP_GXOR = 3'h7;
  // instruction classes
  localparam logic [2:0] ROP_I_COPY = 3'h0;
  localparam logic [2:0] ROP_I_STRING = 3'h1;
  localparam logic [2:0] ROP_I_XFORM = 3'h2;
  localparam logic [2:0] ROP_I_POINT = 3'h3;
  localparam logic [2:0] ROP_I_LINE = 3'h4;
  localparam logic [2:0] ROP_I_ARC = 3'h5;
  localparam logic [2:0] ROP_I_CIRCLE = 3'h6;
  localparam logic [2:0] ROP_I_FILL = 3'h7;
  // axi responses
  localparam logic [1:0] ROP_RESP_OKAY = 2'h0;
  localparam logic [1:0] ROP_RESP_SLVERR = 2'h2;
endpackage : rop_pkg
`default_nettype wire

// *** tb/rop_dmem_model.sv ***
`default_nettype none
module rop_dmem_model (
  input wire logic aclk,
  input wire logic dm_wr_q,
  input wire logic [63:0] dm_data_q,
  input wire logic [63:0] dm_bit_we_q,
  output logic [63:0] mem_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // memory keeps its contents through reset
  logic [63:0] store_q = 64'h0F0F_A5A5_3C3C_FF00;
  assign mem_q = store_q;
  always @(posedge aclk) begin
    if (dm_wr_q) begin
      store_q <= (store_q & ~dm_bit_we_q) | (dm_data_q & dm_bit_we_q);
    end
  end
endmodule // rop_dmem_model
`default_nettype wire

// *** tb/test_raster_op_combiner.sv ***
`default_nettype none
module test_raster_op_combiner;
  timeunit 1ns;
  timeprecision 1ns;
  import rop_pkg::*;
  localparam logic [63:0] src_c = 64'h1234_F0F0_C3C3_00FF;
  localparam logic [15:0] imask_c = 16'h0180;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dm_wr_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, row, rv;
  logic [63:0] dm_data_q, dm_bit_we_q, mem_q, dst, xd, xw;
  logic [15:0] s, r, we;
  logic [2:0] cls;
  logic hs;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int strobes = 0;
  // {ctrl, colour, active, write mask}; codes 001/010 never issued without source
  logic [31:0] rows [24] = '{
    32'h005F_FFFF, 32'h015F_FFFF, 32'h025F_FFFF, 32'h035F_FFFF,
    32'h045F_FFFF, 32'h055F_FFFF, 32'h065F_FFFF, 32'h075F_FFFF,
    32'h405F_FFFF, 32'h435F_FFFF, 32'h445F_FFFF, 32'h455F_FFFF,
    32'h465F_FFFF, 32'h475F_FFFF, 32'hBFC7_FFFF, 32'hF5AF_0FF0,
    32'h1936_FFFF, 32'h259F_0F0F, 32'hD6C5_FFFF, 32'h6350_FFFF,
    32'h05AF_FFFF, 32'h085F_FFFF, 32'h005F_0000, 32'h0B0F_F00F};
  logic [7:0] rst_a [6] = '{ROP_CTRL_OFS, ROP_COLOR_OFS, ROP_SEARCH_OFS,
    ROP_ACTIVE_OFS, ROP_WMASK_OFS, ROP_IMASK_OFS};
  logic [31:0] rst_v [6] = '{{24'h0, ROP_CTRL_RST}, {28'h0, ROP_COLOR_RST},
    {28'h0, ROP_SEARCH_RST}, {28'h0, ROP_ACTIVE_RST}, {16'h0, ROP_WMASK_RST},
    {16'h0, ROP_IMASK_RST}};

  rop_combiner rop_combiner_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .dm_wr_q, .dm_data_q, .dm_bit_we_q);
  rop_dmem_model rop_dmem_model_i (.aclk, .dm_wr_q, .dm_data_q, .dm_bit_we_q, .mem_q);

  always #5 aclk = ~aclk;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // the strobe stands one cycle only, so pulses are counted as they pass
  always @(posedge aclk) begin
    if (dm_wr_q === 1'b1) begin
      strobes++;
    end
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] exp_op(input logic [2:0] k, input logic c,
                                         input logic [15:0] d, input logic [15:0] x);
    case (k)
      3'h0: return x;
      3'h1: return d | x;
      3'h2: return d & x;
      3'h3: return d ^ x;
      3'h4: return d & ~x;
      3'h5: return c ? (d | x) : (d & ~x);
      3'h6: return c ? (d | x) : d;
      default: return c ? (d ^ x) : d;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rr);
    logic aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] rr;
    wr(a, d, rr);
    chk(rr, ROP_RESP_OKAY);
  endtask

  task automatic get(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] rr;
    rd(a, d, rr);
    chk(rr, ROP_RESP_OKAY);
    chk(d, e);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(dm_wr_q, 1'b0);
    chk(dm_data_q, 64'h0000_0000_0000_0000);
    chk(dm_bit_we_q, 64'h0000_0000_0000_0000);
    for (int i = 0; i < 6; i++) get(rst_a[i], rst_v[i]);
    put(ROP_SEARCH_OFS, 32'h0000_0009);
    get(ROP_SEARCH_OFS, 32'h0000_0009);
    put(ROP_IMASK_OFS, {16'h0, imask_c});
    put(ROP_SRC01_OFS, src_c[31:0]);
    put(ROP_SRC23_OFS, src_c[63:32]);
    for (int i = 0; i < 24; i++) begin
      row = rows[i];
      cls = row[30:28];
      hs = (cls <= ROP_I_XFORM) || (row[31] && cls != ROP_I_FILL);
      dst = mem_q;
      put(ROP_CTRL_OFS, {24'h0, row[31:24]});
      put(ROP_COLOR_OFS, {28'h0, row[23:20]});
      get(ROP_COLOR_OFS, {28'h0, row[23:20]});
      put(ROP_ACTIVE_OFS, {28'h0, row[19:16]});
      put(ROP_WMASK_OFS, {16'h0, row[15:0]});
      put(ROP_DST01_OFS, dst[31:0]);
      put(ROP_DST23_OFS, dst[63:32]);
      for (int p = 0; p < ROP_PLANES; p++) begin
        s = hs ? (src_c[16*p+:16] ^ {16{row[27]}}) : imask_c;
        r = exp_op(row[26:24], row[20+p], dst[16*p+:16], s);
        we = row[16+p] ? row[15:0] : 16'h0000;
        xd[16*p+:16] = (r & we) | (dst[16*p+:16] & ~we);
        xw[16*p+:16] = we;
      end
      put(ROP_GO_OFS, 32'h0000_0000);
      #1;
      chk(strobes, i + 1);
      chk(dm_data_q, xd);
      chk(dm_bit_we_q, xw);
      @(posedge aclk);
      #1;
      chk(dm_wr_q, 1'b0);
      chk(mem_q, xd);
      get(ROP_RES01_OFS, xd[31:0]);
      get(ROP_RES23_OFS, xd[63:32]);
      get(ROP_STATUS_OFS, {26'h0, (row[15:0] != 16'h0000) ? row[19:16] : 4'h0, hs, 1'b1});
    end
    // refused accesses must not disturb stored state
    rd(8'h38, rv, rs);
    chk({rs, rv}, {ROP_RESP_SLVERR, 32'h0000_0000});
    wr(8'h3C, 32'h0000_0001, rs);
    chk(rs, ROP_RESP_SLVERR);
    wr(8'h06, 32'h0000_0001, rs);
    chk(rs, ROP_RESP_SLVERR);
    put(ROP_RES01_OFS, 32'hDEAD_BEEF);
    get(ROP_RES01_OFS, xd[31:0]);
    get(ROP_GO_OFS, 32'h0000_0000);
    // only the low byte lane is written; the upper byte keeps F0 from the last row
    s_axi_wstrb <= 4'h1;
    put(ROP_WMASK_OFS, 32'h0000_1234);
    get(ROP_WMASK_OFS, 32'h0000_F034);
    s_axi_wstrb <= 4'hF;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    get(ROP_ACTIVE_OFS, {28'h0, ROP_ACTIVE_RST});
    get(ROP_WMASK_OFS, {16'h0, ROP_WMASK_RST});
    chk(dm_data_q, 64'h0000_0000_0000_0000);
    get(ROP_SEARCH_OFS, {28'h0, ROP_SEARCH_RST});
    wrap_up();
  end
endmodule // test_raster_op_combiner
`default_nettype wire
